/* File: core/rvc_pkg.sv */
package rvc_pkg;

   // ----------------------------------------------------------------
   // Register bus shape and offsets
   // ----------------------------------------------------------------
   localparam int         ADDR_W        = 3;
   localparam int         DATA_W        = 8;
   localparam logic [2:0] ADDR_FIXREF   = 3'h0;
   localparam logic [2:0] ADDR_GEN_A    = 3'h1;
   localparam logic [2:0] ADDR_GEN_B    = 3'h2;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int FIX_READY_BIT  = 7;
   localparam int FIX_ON_BIT     = 6;
   localparam int FIX_SENSE_LSB  = 2;
   localparam int FIX_CONV_LSB   = 0;
   localparam int GAIN_W         = 2;
   localparam int GEN_ON_BIT     = 7;
   localparam int GEN_IDLE_BIT   = 6;
   localparam int GEN_PIN_BIT    = 5;
   localparam int GEN_SRC_LSB    = 2;
   localparam int SRC_W          = 2;
   localparam int CODE_LSB       = 0;
   localparam int CODE_W         = 5;
   localparam int IRQ_W          = 2;
   localparam int IRQ_READY_RISE = 0;
   localparam int IRQ_READY_FALL = 1;

   // ----------------------------------------------------------------
   // Writable bits and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] FIX_WR_MASK   = 8'h4f;
   localparam logic [7:0] GEN_A_WR_MASK = 8'hec;
   localparam logic [7:0] GEN_B_WR_MASK = 8'h1f;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam logic [1:0] IRQ_RESET     = 2'h0;

   // ----------------------------------------------------------------
   // Gain and source encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] GAIN_OFF   = 2'h0;
   localparam logic [1:0] GAIN_X1    = 2'h1;
   localparam logic [1:0] GAIN_X2    = 2'h2;
   localparam logic [1:0] GAIN_X4    = 2'h3;
   localparam logic [1:0] SRC_SUPPLY = 2'h0;
   localparam logic [1:0] SRC_EXTPIN = 2'h1;
   localparam logic [1:0] SRC_FIXED  = 2'h2;

   // ----------------------------------------------------------------
   // Stabilisation timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          STAB_TIME_NS  = 20000;
   localparam int          STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          STAB_CNT_W    = 12;
   localparam logic [11:0] STAB_LAST     = 12'(STAB_CYCLES - 1);

   // Settling sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_READY} rvc_settle_type;

endpackage : rvc_pkg

/* File: core/rvc_ready_timer.sv */
`timescale 1ns/1ns
module rvc_ready_timer
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // Reference enable from control register
   input  wire logic enable_in,
   // Stable indication
   output logic      ready_out
);

   rvc_pkg::rvc_settle_type state_q;
   rvc_pkg::rvc_settle_type state_d;
   logic [11:0]             cnt_q;
   logic [11:0]             cnt_d;

   // ----------------------------------------------------------------
   // Settling sequencer
   // ----------------------------------------------------------------

   // Next state and settle count
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         rvc_pkg::ST_IDLE:
         begin
            cnt_d = 12'h000;
            if (enable_in)
               state_d = rvc_pkg::ST_SETTLE;
         end
         rvc_pkg::ST_SETTLE:
         begin
            if (!enable_in)
               state_d = rvc_pkg::ST_IDLE;
            else if (cnt_q == rvc_pkg::STAB_LAST)
               state_d = rvc_pkg::ST_READY;
            else
               cnt_d = cnt_q + 12'h001;
         end
         rvc_pkg::ST_READY:
         begin
            if (!enable_in)
               state_d = rvc_pkg::ST_IDLE;
         end
         default:
         begin
            state_d = rvc_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_q   <= rvc_pkg::ST_IDLE;
         cnt_q     <= 12'h000;
         ready_out <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         ready_out <= (state_d == rvc_pkg::ST_READY);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   // Consecutive cycles with the reference on
   logic [11:0] on_cnt_q;
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         on_cnt_q <= 12'h000;
      else if (!enable_in)
         on_cnt_q <= 12'h000;
      else if (on_cnt_q != 12'hfff)
         on_cnt_q <= on_cnt_q + 12'h001;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   property p_ready_early;
      ready_out |-> (on_cnt_q > rvc_pkg::STAB_LAST);
   endproperty
   a_ready_early: assert property (p_ready_early) else $error("ready too early");
   property p_ready_late;
      (on_cnt_q == rvc_pkg::STAB_LAST + 12'h003) |-> ready_out;
   endproperty
   a_ready_late: assert property (p_ready_late) else $error("ready too late");

endmodule : rvc_ready_timer

/* File: core/rvc_top.sv */
// Operation
// - Reference and gain amplifiers are powered only while the on bit is one.
// - Ready flag stays low until the settle time passes, then goes high; with WIDE_SUPPLY set it reads high always.
// - Converter gain field: off, 1x, 2x or 4x of the base level.
// - Sense/level gain field decoded the same way, independent of converter.
// - Level generator off zeroes its code, ties the output low or high by idle select and removes its power.
// - Five-bit level code picks one of 32 output levels.
// - Pin drive bit routes level to pin and cuts digital buffer and input.
// - Digital read of the level pin returns zero while in reference mode.
// - Waking from sleep leaves the first generator register unchanged.
// - Idle select picks negative or positive source while generator is off.
// - Reset clears level code and disables reference and generator.
// - Reset returns the level pin to normal digital use.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module rvc_top
#(
   parameter bit WIDE_SUPPLY = 1'b0
)
(
   // Clock and reset
   input  wire logic       MCLK_IN,
   input  wire logic       ARST_N_IN,
   // Register port
   input  wire logic [2:0] ADDR_IN,
   input  wire logic [7:0] WR_DATA_IN,
   input  wire logic       WR_STB_IN,
   input  wire logic       RD_STB_IN,
   output logic      [7:0] RD_DATA_OUT,
   // Interrupt
   output logic            IRQ_OUT,
   // Fixed reference controls
   output logic            REF_POWER_OUT,
   output logic      [2:0] CONV_GAIN_OUT,
   output logic      [2:0] SENSE_GAIN_OUT,
   // Level generator controls
   output logic            LEVEL_GEN_POWER_OUT,
   output logic      [4:0] LEVEL_CODE_OUT,
   output logic      [2:0] LEVEL_SRC_OUT,
   output logic            LEVEL_TIE_LOW_OUT,
   output logic            LEVEL_TIE_HIGH_OUT,
   // Level output pin
   input  wire logic       PIN_DOUT_IN,
   input  wire logic       PIN_DOE_IN,
   input  wire logic       LEVEL_OUT_PIN_IN,
   output logic            LEVEL_OUT_PIN_OUT,
   output logic            LEVEL_OUT_PIN_OE_OUT,
   output logic            LEVEL_PIN_ANALOG_OUT,
   output logic            PIN_READ_OUT
);

   logic [7:0] fixref_q;
   logic [7:0] fixref_d;
   logic [7:0] gen_a_q;
   logic [7:0] gen_a_d;
   logic [7:0] gen_b_q;
   logic [7:0] gen_b_d;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic [1:0] mask_d;
   logic       ready_w;
   logic       ready_prev_q;
   logic       ready_rd;
   logic [7:0] rd_data_d;
   logic       irq_d;
   logic [1:0] gain_sel [2];
   logic [2:0] gain_hot_d [2];
   logic       lvl_power_d;
   logic [4:0] lvl_code_d;
   logic [2:0] lvl_src_d;
   logic       tie_low_d;
   logic       tie_high_d;
   logic       pin_s1_q;
   logic       pin_s2_q;
   logic       pin_s3_q;
   logic       pin_filt_q;
   logic       pin_filt_d;
   logic       pin_analog_d;
   logic       pin_out_d;
   logic       pin_oe_d;
   logic       pin_read_d;
   logic       wr_fix;
   logic       wr_gen_a;
   logic       wr_gen_b;

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------

   // Write decode
   assign wr_fix   = WR_STB_IN && (ADDR_IN == rvc_pkg::ADDR_FIXREF);
   assign wr_gen_a = WR_STB_IN && (ADDR_IN == rvc_pkg::ADDR_GEN_A);
   assign wr_gen_b = WR_STB_IN && (ADDR_IN == rvc_pkg::ADDR_GEN_B);

   // Next register values; only bus writes change them
   always_comb
   begin
      fixref_d = fixref_q;
      gen_a_d  = gen_a_q;
      gen_b_d  = gen_b_q;
      mask_d   = mask_q;
      if (wr_fix)
         fixref_d = WR_DATA_IN & rvc_pkg::FIX_WR_MASK;
      if (wr_gen_a)
         gen_a_d = WR_DATA_IN & rvc_pkg::GEN_A_WR_MASK;
      if (wr_gen_b)
         gen_b_d = WR_DATA_IN & rvc_pkg::GEN_B_WR_MASK;
      if (WR_STB_IN && (ADDR_IN == rvc_pkg::ADDR_IRQ_MASK))
         mask_d = WR_DATA_IN[1:0];
   end

   // Control registers, all cleared by reset
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         fixref_q <= rvc_pkg::REG_RESET;
         gen_a_q  <= rvc_pkg::REG_RESET;
         gen_b_q  <= rvc_pkg::REG_RESET;
         mask_q   <= rvc_pkg::IRQ_RESET;
      end
      else
      begin
         fixref_q <= fixref_d;
         gen_a_q  <= gen_a_d;
         gen_b_q  <= gen_b_d;
         mask_q   <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // Fixed reference and gain amplifiers
   // ----------------------------------------------------------------

   // Settling timer
   rvc_ready_timer u_ready
   (
      .clk_in    (MCLK_IN),
      .arst_n_in (ARST_N_IN),
      .enable_in (fixref_q[rvc_pkg::FIX_ON_BIT]),
      .ready_out (ready_w)
   );

   // Variant forces ready high on reads
   assign ready_rd = WIDE_SUPPLY | ready_w;

   // Gain field selects, converter then sense path
   assign gain_sel[0] = fixref_q[rvc_pkg::FIX_CONV_LSB +: rvc_pkg::GAIN_W];
   assign gain_sel[1] = fixref_q[rvc_pkg::FIX_SENSE_LSB +: rvc_pkg::GAIN_W];

   // One-hot amplifier selects, dark while reference is off
   for (genvar g = 0; g < 2; g++)
   begin : g_gain
      always_comb
      begin
         gain_hot_d[g] = 3'h0;
         if (fixref_q[rvc_pkg::FIX_ON_BIT])
         begin
            case (gain_sel[g])
               rvc_pkg::GAIN_X1: gain_hot_d[g] = 3'h1;
               rvc_pkg::GAIN_X2: gain_hot_d[g] = 3'h2;
               rvc_pkg::GAIN_X4: gain_hot_d[g] = 3'h4;
               default:          gain_hot_d[g] = 3'h0;
            endcase
         end
      end
   end

   // Reference output registers
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         REF_POWER_OUT  <= 1'b0;
         CONV_GAIN_OUT  <= 3'h0;
         SENSE_GAIN_OUT <= 3'h0;
      end
      else
      begin
         REF_POWER_OUT  <= fixref_q[rvc_pkg::FIX_ON_BIT];
         CONV_GAIN_OUT  <= gain_hot_d[0];
         SENSE_GAIN_OUT <= gain_hot_d[1];
      end
   end

   // ----------------------------------------------------------------
   // Level generator
   // ----------------------------------------------------------------

   // Generator power, code, source and idle tie
   always_comb
   begin
      lvl_power_d = gen_a_q[rvc_pkg::GEN_ON_BIT];
      lvl_code_d  = 5'h00;
      if (lvl_power_d)
         lvl_code_d = gen_b_q[rvc_pkg::CODE_LSB +: rvc_pkg::CODE_W];
      tie_low_d  = !lvl_power_d && !gen_a_q[rvc_pkg::GEN_IDLE_BIT];
      tie_high_d = !lvl_power_d && gen_a_q[rvc_pkg::GEN_IDLE_BIT];
      case (gen_a_q[rvc_pkg::GEN_SRC_LSB +: rvc_pkg::SRC_W])
         rvc_pkg::SRC_SUPPLY: lvl_src_d = 3'h1;
         rvc_pkg::SRC_EXTPIN: lvl_src_d = 3'h2;
         rvc_pkg::SRC_FIXED:  lvl_src_d = 3'h4;
         default:             lvl_src_d = 3'h0;
      endcase
   end

   // Generator output registers
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         LEVEL_GEN_POWER_OUT <= 1'b0;
         LEVEL_CODE_OUT      <= 5'h00;
         LEVEL_SRC_OUT       <= 3'h0;
         LEVEL_TIE_LOW_OUT   <= 1'b0;
         LEVEL_TIE_HIGH_OUT  <= 1'b0;
      end
      else
      begin
         LEVEL_GEN_POWER_OUT <= lvl_power_d;
         LEVEL_CODE_OUT      <= lvl_code_d;
         LEVEL_SRC_OUT       <= lvl_src_d;
         LEVEL_TIE_LOW_OUT   <= tie_low_d;
         LEVEL_TIE_HIGH_OUT  <= tie_high_d;
      end
   end

   // ----------------------------------------------------------------
   // Level output pin
   // ----------------------------------------------------------------

   // Pin filter and analog takeover
   always_comb
   begin
      pin_filt_d = pin_filt_q;
      if (pin_s2_q == pin_s3_q)
         pin_filt_d = pin_s3_q;
      pin_analog_d = gen_a_q[rvc_pkg::GEN_PIN_BIT];
      pin_oe_d     = PIN_DOE_IN && !pin_analog_d;
      pin_out_d    = PIN_DOUT_IN && !pin_analog_d;
      pin_read_d   = pin_filt_q && !pin_analog_d;
   end

   // Pin synchroniser and pin registers
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         pin_s1_q             <= 1'b0;
         pin_s2_q             <= 1'b0;
         pin_s3_q             <= 1'b0;
         pin_filt_q           <= 1'b0;
         LEVEL_PIN_ANALOG_OUT <= 1'b0;
         LEVEL_OUT_PIN_OE_OUT <= 1'b0;
         LEVEL_OUT_PIN_OUT    <= 1'b0;
         PIN_READ_OUT         <= 1'b0;
      end
      else
      begin
         pin_s1_q             <= LEVEL_OUT_PIN_IN;
         pin_s2_q             <= pin_s1_q;
         pin_s3_q             <= pin_s2_q;
         pin_filt_q           <= pin_filt_d;
         LEVEL_PIN_ANALOG_OUT <= pin_analog_d;
         LEVEL_OUT_PIN_OE_OUT <= pin_oe_d;
         LEVEL_OUT_PIN_OUT    <= pin_out_d;
         PIN_READ_OUT         <= pin_read_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts and read data
   // ----------------------------------------------------------------

   // Sticky events, set wins over write-one clear
   always_comb
   begin
      stat_d = stat_q;
      if (WR_STB_IN && (ADDR_IN == rvc_pkg::ADDR_IRQ_STAT))
         stat_d = stat_q & ~WR_DATA_IN[1:0];
      if (ready_w && !ready_prev_q)
         stat_d[rvc_pkg::IRQ_READY_RISE] = 1'b1;
      if (!ready_w && ready_prev_q)
         stat_d[rvc_pkg::IRQ_READY_FALL] = 1'b1;
      irq_d = |(stat_q & mask_q);
   end

   // Read mux, zero outside the answer cycle and for unmapped offsets
   always_comb
   begin
      rd_data_d = 8'h00;
      if (RD_STB_IN)
      begin
         case (ADDR_IN)
            rvc_pkg::ADDR_FIXREF:   rd_data_d = {ready_rd, fixref_q[6:0]};
            rvc_pkg::ADDR_GEN_A:    rd_data_d = gen_a_q;
            rvc_pkg::ADDR_GEN_B:    rd_data_d = gen_b_q;
            rvc_pkg::ADDR_IRQ_STAT: rd_data_d = {6'h00, stat_q};
            rvc_pkg::ADDR_IRQ_MASK: rd_data_d = {6'h00, mask_q};
            default:                rd_data_d = 8'h00;
         endcase
      end
   end

   // Status and answer registers
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         stat_q       <= rvc_pkg::IRQ_RESET;
         ready_prev_q <= 1'b0;
         IRQ_OUT      <= 1'b0;
         RD_DATA_OUT  <= 8'h00;
      end
      else
      begin
         stat_q       <= stat_d;
         ready_prev_q <= ready_w;
         IRQ_OUT      <= irq_d;
         RD_DATA_OUT  <= rd_data_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   property p_ref_power;
      fixref_q[rvc_pkg::FIX_ON_BIT] != REF_POWER_OUT |=> REF_POWER_OUT == $past(fixref_q[6]);
   endproperty
   a_ref_power: assert property (p_ref_power) else $error("reference power wrong");
   property p_ready_read;
      RD_STB_IN && ADDR_IN == rvc_pkg::ADDR_FIXREF |=> RD_DATA_OUT[7] == (WIDE_SUPPLY | $past(ready_w))
         && RD_DATA_OUT[5:4] == 2'h0;
   endproperty
   a_ready_read: assert property (p_ready_read) else $error("reference read wrong");
   property p_conv_gain;
      fixref_q[rvc_pkg::FIX_ON_BIT] && fixref_q[1:0] == rvc_pkg::GAIN_X2 |=> CONV_GAIN_OUT == 3'h2;
   endproperty
   a_conv_gain: assert property (p_conv_gain) else $error("converter gain wrong");
   property p_sense_gain;
      fixref_q[rvc_pkg::FIX_ON_BIT] && fixref_q[3:2] == rvc_pkg::GAIN_X4 && fixref_q[1:0] == 2'h0
         |=> SENSE_GAIN_OUT == 3'h4 && CONV_GAIN_OUT == 3'h0;
   endproperty
   a_sense_gain: assert property (p_sense_gain) else $error("sense gain wrong");
   property p_gen_off;
      !gen_a_q[rvc_pkg::GEN_ON_BIT] |=> !LEVEL_GEN_POWER_OUT && LEVEL_CODE_OUT == 5'h00
         && (LEVEL_TIE_HIGH_OUT == $past(gen_a_q[6]));
   endproperty
   a_gen_off: assert property (p_gen_off) else $error("generator not idled");
   property p_gen_code;
      gen_a_q[rvc_pkg::GEN_ON_BIT] |=> LEVEL_CODE_OUT == $past(gen_b_q[4:0]);
   endproperty
   a_gen_code: assert property (p_gen_code) else $error("level code wrong");
   property p_pin_take;
      gen_a_q[rvc_pkg::GEN_PIN_BIT] |=> LEVEL_PIN_ANALOG_OUT && !LEVEL_OUT_PIN_OE_OUT && !PIN_READ_OUT;
   endproperty
   a_pin_take: assert property (p_pin_take) else $error("pin not taken over");
   property p_pin_read;
      LEVEL_PIN_ANALOG_OUT |-> !PIN_READ_OUT;
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin read not zero");
   property p_gen_a_hold;
      !wr_gen_a |=> gen_a_q == $past(gen_a_q);
   endproperty
   a_gen_a_hold: assert property (p_gen_a_hold) else $error("generator control changed");

   c_ready:   cover property (ready_w && !ready_prev_q);
   c_irq:     cover property (IRQ_OUT);
   c_analog:  cover property (LEVEL_PIN_ANALOG_OUT && LEVEL_GEN_POWER_OUT);
   c_src_fix: cover property (LEVEL_SRC_OUT == 3'h4);

endmodule : rvc_top

/* File: verif/rvc_top_tb_top.sv */
`timescale 1ns/1ns
module rvc_top_tb_top;

   // ----------------------------------------------------------------
   // Bench signals
   // ----------------------------------------------------------------
   logic       mclk;
   logic       arst_n;
   logic [2:0] addr;
   logic [7:0] wr_data;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rd_data;
   logic [7:0] rd_wide;
   logic       irq;
   logic       ref_power;
   logic [2:0] conv_gain;
   logic [2:0] sense_gain;
   logic       gen_power;
   logic [4:0] level_code;
   logic [2:0] level_src;
   logic       tie_low;
   logic       tie_high;
   logic       pin_dout;
   logic       pin_doe;
   logic       pad_in;
   logic       pad_out;
   logic       pad_oe;
   logic       pin_analog;
   logic       pin_read;
   logic [7:0] d;
   int         n_errors;
   int         checked;

   // Main instance, narrow-supply variant
   rvc_top u_dut
   (
      .MCLK_IN              (mclk),
      .ARST_N_IN            (arst_n),
      .ADDR_IN              (addr),
      .WR_DATA_IN           (wr_data),
      .WR_STB_IN            (wr_stb),
      .RD_STB_IN            (rd_stb),
      .RD_DATA_OUT          (rd_data),
      .IRQ_OUT              (irq),
      .REF_POWER_OUT        (ref_power),
      .CONV_GAIN_OUT        (conv_gain),
      .SENSE_GAIN_OUT       (sense_gain),
      .LEVEL_GEN_POWER_OUT  (gen_power),
      .LEVEL_CODE_OUT       (level_code),
      .LEVEL_SRC_OUT        (level_src),
      .LEVEL_TIE_LOW_OUT    (tie_low),
      .LEVEL_TIE_HIGH_OUT   (tie_high),
      .PIN_DOUT_IN          (pin_dout),
      .PIN_DOE_IN           (pin_doe),
      .LEVEL_OUT_PIN_IN     (pad_in),
      .LEVEL_OUT_PIN_OUT    (pad_out),
      .LEVEL_OUT_PIN_OE_OUT (pad_oe),
      .LEVEL_PIN_ANALOG_OUT (pin_analog),
      .PIN_READ_OUT         (pin_read)
   );

   // Wide-supply variant, only its read data is watched
   rvc_top #(.WIDE_SUPPLY(1'b1)) u_wide
   (
      .MCLK_IN(mclk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WR_DATA_IN(wr_data),
      .WR_STB_IN(wr_stb), .RD_STB_IN(rd_stb), .RD_DATA_OUT(rd_wide), .IRQ_OUT(),
      .REF_POWER_OUT(), .CONV_GAIN_OUT(), .SENSE_GAIN_OUT(), .LEVEL_GEN_POWER_OUT(),
      .LEVEL_CODE_OUT(), .LEVEL_SRC_OUT(), .LEVEL_TIE_LOW_OUT(), .LEVEL_TIE_HIGH_OUT(),
      .PIN_DOUT_IN(pin_dout), .PIN_DOE_IN(pin_doe), .LEVEL_OUT_PIN_IN(pad_in),
      .LEVEL_OUT_PIN_OUT(), .LEVEL_OUT_PIN_OE_OUT(), .LEVEL_PIN_ANALOG_OUT(),
      .PIN_READ_OUT()
   );

   // Clock, 8 ns period
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk);
      wr_stb  <= 1'b1;
      addr    <= a;
      wr_data <= v;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask : wr

   // Read data is taken in the single cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1;
      d = rd_data;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : settle

   function automatic logic [7:0] onehot(input int g);
      return (g == 0) ? 8'h00 : 8'(1 << (g - 1));
   endfunction : onehot

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk("outs_reset", 8'({ref_power, gen_power, pin_analog, level_code}), 8'h00);
      for (int a = 0; a < 8; a++)
      begin
         rd(a[2:0]);
         chk("reg_reset", d, 8'h00);
         if (a == 0)
            chk("wide_ready", rd_wide, 8'h80);
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_ready;
      wr(rvc_pkg::ADDR_IRQ_MASK, 8'h01);
      wr(rvc_pkg::ADDR_FIXREF, 8'h40);
      rd(rvc_pkg::ADDR_FIXREF);
      chk("ready_early", d, 8'h40);
      settle(2400);
      rd(rvc_pkg::ADDR_FIXREF);
      chk("ready_late_low", d, 8'h40);
      chk("irq_quiet", 8'(irq), 8'h00);
      settle(120);
      rd(rvc_pkg::ADDR_FIXREF);
      chk("ready_set", d, 8'hc0);
      rd(rvc_pkg::ADDR_IRQ_STAT);
      chk("stat_rise", d, 8'h01);
      chk("irq_on", 8'(irq), 8'h01);
      wr(rvc_pkg::ADDR_IRQ_STAT, 8'h01);
      settle(2);
      chk("irq_cleared", 8'(irq), 8'h00);
      // Switching off drops ready; the fall event is masked out
      wr(rvc_pkg::ADDR_FIXREF, 8'h00);
      settle(4);
      rd(rvc_pkg::ADDR_FIXREF);
      chk("ready_off", d, 8'h00);
      rd(rvc_pkg::ADDR_IRQ_STAT);
      chk("stat_fall", d, 8'h02);
      chk("irq_masked", 8'(irq), 8'h00);
      wr(rvc_pkg::ADDR_IRQ_STAT, 8'h02);
      rd(rvc_pkg::ADDR_IRQ_STAT);
      chk("stat_clear", d, 8'h00);
      $display("test ready done");
   endtask : t_ready

   task automatic t_gain;
      for (int g = 0; g < 4; g++)
      begin
         wr(rvc_pkg::ADDR_FIXREF, 8'h40 | 8'((3 - g) << 2) | 8'(g));
         settle(2);
         chk("conv_gain", 8'(conv_gain), onehot(g));
         chk("sense_gain", 8'(sense_gain), onehot(3 - g));
         chk("ref_power", 8'(ref_power), 8'h01);
      end
      wr(rvc_pkg::ADDR_FIXREF, 8'h3f);
      settle(2);
      chk("gain_ref_off", 8'({ref_power, conv_gain, sense_gain}), 8'h00);
      rd(rvc_pkg::ADDR_FIXREF);
      chk("reserved_zero", d, 8'h0f);
      $display("test gain done");
   endtask : t_gain

   task automatic t_gen;
      wr(rvc_pkg::ADDR_GEN_B, 8'hff);
      rd(rvc_pkg::ADDR_GEN_B);
      chk("code_mask", d, 8'h1f);
      wr(rvc_pkg::ADDR_GEN_A, 8'h00);
      settle(2);
      chk("gen_off_low", 8'({gen_power, tie_low, tie_high, level_code}), 8'h40);
      wr(rvc_pkg::ADDR_GEN_A, 8'h40);
      settle(2);
      chk("gen_off_high", 8'({gen_power, tie_low, tie_high, level_code}), 8'h20);
      for (int s = 0; s < 4; s++)
      begin
         wr(rvc_pkg::ADDR_GEN_A, 8'h80 | 8'(s << 2));
         settle(2);
         chk("level_src", 8'(level_src), (s == 3) ? 8'h00 : onehot(s + 1));
         chk("gen_on", 8'({gen_power, tie_low, tie_high, level_code}), 8'h9f);
      end
      for (int c = 0; c < 32; c += 15)
      begin
         wr(rvc_pkg::ADDR_GEN_B, 8'(c));
         settle(2);
         chk("level_code", 8'(level_code), 8'(c));
      end
      wr(rvc_pkg::ADDR_GEN_A, 8'hff);
      rd(rvc_pkg::ADDR_GEN_A);
      chk("gen_a_mask", d, 8'hec);
      $display("test generator done");
   endtask : t_gen

   task automatic t_pin;
      @(posedge mclk);
      pin_dout <= 1'b1;
      pin_doe  <= 1'b1;
      pad_in   <= 1'b1;
      wr(rvc_pkg::ADDR_GEN_A, 8'h00);
      settle(10);
      chk("pin_digital", 8'({pin_analog, pad_oe, pad_out, pin_read}), 8'h07);
      wr(rvc_pkg::ADDR_GEN_A, 8'h20);
      settle(3);
      chk("pin_analog", 8'({pin_analog, pad_oe, pad_out, pin_read}), 8'h08);
      // Reset in mid-run while the level owns the pin
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      settle(10);
      chk("pin_after_reset", 8'({pin_analog, pad_oe, pad_out, pin_read}), 8'h07);
      rd(rvc_pkg::ADDR_GEN_B);
      chk("code_after_reset", d, 8'h00);
      $display("test pin done");
   endtask : t_pin

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      n_errors = 0;
      checked  = 0;
      arst_n   = 1'b0;
      addr     = 3'h0;
      wr_data  = 8'h00;
      wr_stb   = 1'b0;
      rd_stb   = 1'b0;
      pin_dout = 1'b0;
      pin_doe  = 1'b0;
      pad_in   = 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      settle(1);
      t_reset();
      t_ready();
      t_gain();
      t_gen();
      t_pin();
      wrap_up();
   end

   // Run needs about 2700 cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("[ERR] watchdog expected end seen hang");
      wrap_up();
   end

endmodule : rvc_top_tb_top
